// ===== rtl/twx_pkg.sv
// package: constants for the two-wire i/o expander target
package twx_pkg;
  localparam int      CLK_PERIOD_NS  = 8;
  localparam int      SPIKE_NS       = 50;
  // filter must outlast a spike: round up, at least one cycle
  localparam int      SPIKE_CYC      = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int      PORT_DLY_US    = 4;
  // longest delay rounds down
  localparam int      PORT_DLY_CYC   = (PORT_DLY_US * 1000) / CLK_PERIOD_NS;
  localparam int      FLT_W          = 4;
  localparam logic [3:0] FIXED_ADDR  = 4'h4;
  localparam logic [6:0] GCALL_ADDR  = 7'h00;
  localparam logic [7:0] PORT_RST    = 8'hff;
  localparam int      FIFO_DEPTH     = 16;
  localparam int      FIFO_WIDTH     = 8;
  typedef enum logic [2:0] {
    TWX_IDLE  = 3'b000,
    TWX_ADDR  = 3'b001,
    TWX_AACK  = 3'b010,
    TWX_WDAT  = 3'b011,
    TWX_WACK  = 3'b100,
    TWX_RDAT  = 3'b101,
    TWX_RACK  = 3'b110,
    TWX_SKIP  = 3'b111
  } twx_state_t;
endpackage

// ===== rtl/twx_fifo.sv
// module: parameterised valid/ready fifo for written port bytes
`timescale 1ns/1ns
`default_nettype none
module twx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i,
  output var  logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;
  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      wr_q <= '0;
    else if (in_valid_i && !full)
      wr_q <= wr_q + 1'b1;
  always_ff @(posedge mclk_i)
    if (in_valid_i && !full)
      mem_q[wr_q[AW-1:0]] <= in_data_i;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      rd_q <= '0;
    else if (out_ready_i && !empty)
      rd_q <= rd_q + 1'b1;
endmodule
`default_nettype wire

// ===== rtl/twx_target.sv
// module: two-wire target port of an 8-bit quasi-bidirectional i/o expander
// Functional notes
// - one data bit is taken per serial clock pulse
// - data changing while clock high is a control condition, not data
// - both lines high means the bus is idle
// - data falling while clock high is start; detected
// - data rising while clock high is stop; return to idle
// - address byte follows start, msb first, direction bit last
// - general call address is never acknowledged
// - any number of data bytes between start and stop
// - every byte is followed by one acknowledge slot on a ninth pulse
// - addressed receiver acknowledges every byte; a written data byte arriving while the fifo is full is not acknowledged
// - transmitter releases data before the acknowledge slot
// - acknowledger holds data low through the acknowledge pulse high time
// - after not-acknowledge the device leaves data released
// - clock and data inputs ignore spikes shorter than 50 ns
// - written port outputs valid within 4 us of the completing edge
// - change alert goes low within 4 us of a port input change
// - change alert released within 4 us of a port access clock edge
// - direction bit one selects read, zero selects write
`timescale 1ns/1ns
`default_nettype none
module twx_target
  import twx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_o,
  input  wire logic [2:0] addr_select_pins_i,
  input  wire logic [7:0] quasi_io_pins_i,
  output var  logic [7:0] quasi_io_pins_o,
  output var  logic [7:0] quasi_io_pins_oe_o,
  output var  logic       alert_n_o,
  output var  logic       alert_n_oe_o,
  output var  logic       wr_stall_o
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and spike filters
  logic [1:0]       scl_s_q, sda_s_q;
  logic [2:0]       adr_s1_q, adr_s2_q;
  logic [7:0]       pin_s1_q, pin_s2_q;
  logic [FLT_W-1:0] scl_cnt_q, sda_cnt_q;
  logic             scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      scl_s_q  <= 2'h3;
      sda_s_q  <= 2'h3;
      adr_s1_q <= 3'h0;
      adr_s2_q <= 3'h0;
      pin_s1_q <= 8'hff;
      pin_s2_q <= 8'hff;
    end
    else
    begin
      scl_s_q  <= {scl_s_q[0], scl_i};
      sda_s_q  <= {sda_s_q[0], sda_i};
      adr_s1_q <= addr_select_pins_i;
      adr_s2_q <= adr_s1_q;
      pin_s1_q <= quasi_io_pins_i;
      pin_s2_q <= pin_s1_q;
    end
  // a level must persist SPIKE_CYC + 1 cycles before the filtered line follows
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      scl_cnt_q <= '0;
      sda_cnt_q <= '0;
      scl_f_q   <= 1'b1;
      sda_f_q   <= 1'b1;
    end
    else
    begin
      if (scl_s_q[1] == scl_f_q)
        scl_cnt_q <= '0;
      else if (scl_cnt_q == FLT_W'(SPIKE_CYC))
      begin
        scl_f_q   <= scl_s_q[1];
        scl_cnt_q <= '0;
      end
      else
        scl_cnt_q <= scl_cnt_q + 1'b1;
      if (sda_s_q[1] == sda_f_q)
        sda_cnt_q <= '0;
      else if (sda_cnt_q == FLT_W'(SPIKE_CYC))
      begin
        sda_f_q   <= sda_s_q[1];
        sda_cnt_q <= '0;
      end
      else
        sda_cnt_q <= sda_cnt_q + 1'b1;
    end
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  logic scl_rise, scl_fall, start_det, stop_det, bus_idle;
  assign scl_rise  = scl_f_q && !scl_p_q;
  assign scl_fall  = !scl_f_q && scl_p_q;
  assign start_det = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
  assign stop_det  = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
  assign bus_idle  = scl_f_q && sda_f_q;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  twx_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] shr_q;
  logic [7:0] tx_q;
  logic       rw_q;
  logic       drive_low_q;
  logic       push_q;
  logic [7:0] push_data_q;
  logic       acc_q;
  logic       fifo_ready;
  logic       addr_hit;
  assign addr_hit = (shr_q[7:1] == {FIXED_ADDR, adr_s2_q}) &&
                    (shr_q[7:1] != GCALL_ADDR);
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      state_q     <= TWX_IDLE;
      bit_q       <= 4'h0;
      shr_q       <= 8'h00;
      tx_q        <= 8'hff;
      rw_q        <= 1'b0;
      drive_low_q <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= 8'h00;
      acc_q       <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      acc_q  <= 1'b0;
      if (start_det)
      begin
        state_q     <= TWX_ADDR;
        bit_q       <= 4'h0;
        drive_low_q <= 1'b0;
      end
      else if (stop_det)
      begin
        state_q     <= TWX_IDLE;
        drive_low_q <= 1'b0;
      end
      else
        case (state_q)
          TWX_ADDR, TWX_WDAT:
            if (scl_rise)
            begin
              shr_q <= {shr_q[6:0], sda_f_q};
              bit_q <= bit_q + 1'b1;
            end
            else if (scl_fall && bit_q == 4'h8)
            begin
              bit_q <= 4'h0;
              if (state_q == TWX_WDAT)
              begin
                drive_low_q <= fifo_ready;
                push_q      <= fifo_ready;
                push_data_q <= shr_q;
                acc_q       <= 1'b1;
                state_q     <= TWX_WACK;
              end
              else if (addr_hit)
              begin
                rw_q        <= shr_q[0];
                drive_low_q <= 1'b1;
                state_q     <= TWX_AACK;
              end
              else
                state_q <= TWX_SKIP;
            end
          TWX_AACK, TWX_WACK:
            if (scl_fall)
            begin
              if (rw_q)
              begin
                tx_q        <= pin_s2_q;
                drive_low_q <= !pin_s2_q[7];
                bit_q       <= 4'h1;
                acc_q       <= 1'b1;
                state_q     <= TWX_RDAT;
              end
              else
              begin
                drive_low_q <= 1'b0;
                state_q     <= TWX_WDAT;
              end
            end
          TWX_RDAT:
            if (scl_fall)
            begin
              if (bit_q == 4'h8)
              begin
                drive_low_q <= 1'b0;
                state_q     <= TWX_RACK;
              end
              else
              begin
                drive_low_q <= !tx_q[3'(7 - bit_q)];
                bit_q       <= bit_q + 1'b1;
              end
            end
          TWX_RACK:
            if (scl_rise)
            begin
              if (sda_f_q)
                state_q <= TWX_SKIP;
              else
                state_q <= TWX_AACK;
            end
          TWX_IDLE, TWX_SKIP:
            drive_low_q <= 1'b0;
          default:
            state_q <= TWX_IDLE;
        endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // written bytes queue up, then reach the port latch
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] port_q;
  logic [7:0] drain_cnt_q;
  logic       drain_ok;
  // pace the drain so each written value stands before the next; full fifo nacks
  assign drain_ok = (drain_cnt_q == 8'h00);
  twx_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .in_valid_i (push_q),
    .in_ready_o (fifo_ready),
    .in_data_i  (push_data_q),
    .out_valid_o(fifo_valid),
    .out_ready_i(drain_ok),
    .out_data_o (fifo_data)
  );
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      port_q      <= PORT_RST;
      drain_cnt_q <= 8'h00;
    end
    else if (fifo_valid && drain_ok)
    begin
      port_q      <= fifo_data;
      drain_cnt_q <= 8'h0f;
    end
    else if (!drain_ok)
      drain_cnt_q <= drain_cnt_q - 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // change alert and pin drivers
  logic [7:0] snap_q;
  logic [7:0] pin_p_q;
  logic       alert_q;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      snap_q  <= 8'hff;
      pin_p_q <= 8'hff;
      alert_q <= 1'b0;
    end
    else
    begin
      pin_p_q <= pin_s2_q;
      if (acc_q)
      begin
        // snapshot matches the byte loaded a cycle earlier; a move now keeps the alert
        snap_q  <= pin_p_q;
        alert_q <= (pin_s2_q != pin_p_q);
      end
      else if (pin_s2_q != snap_q)
        alert_q <= 1'b1;
    end
  logic unused_idle;
  assign unused_idle = bus_idle;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      sda_o              <= 1'b0;
      sda_oe_o           <= 1'b0;
      quasi_io_pins_o    <= 8'h00;
      quasi_io_pins_oe_o <= 8'h00;
      alert_n_o          <= 1'b0;
      alert_n_oe_o       <= 1'b0;
      wr_stall_o         <= 1'b0;
    end
    else
    begin
      sda_oe_o           <= drive_low_q && !unused_idle;
      quasi_io_pins_oe_o <= ~port_q;
      alert_n_oe_o       <= alert_q;
      wr_stall_o         <= !fifo_ready;
    end
endmodule
`default_nettype wire

// ===== bench/twx_host.sv
// partner: behavioural two-wire bus controller, open-drain data, push-pull clock
`timescale 1ns/1ns
`default_nettype none
module twx_host (
  output var  logic scl_o,
  output var  logic sda_low_o,
  input  wire logic sda_i
);
  // half period longer than the bench link rate: a 32 ns phase would be a spike
  localparam int HALF = 200;
  logic glitch;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    glitch = 1'b0;
  end
  ////////////////////////////////////////
  // data bits move only mid-way through clock low
  task automatic put_bit(input logic b, output logic s);
    #(HALF/2) sda_low_o = !b;
    #(HALF/2) scl_o = 1'b1;
    s = sda_i;
    if (glitch)
    begin
      #60 scl_o = 1'b0;
      #40 scl_o = 1'b1;
      #(HALF-100) scl_o = 1'b0;
    end
    else
      #(HALF) scl_o = 1'b0;
  endtask
  task automatic start;
    sda_low_o = 1'b1;
    #(HALF) scl_o = 1'b0;
  endtask
  task automatic stop;
    #(HALF/2) sda_low_o = 1'b1;
    #(HALF/2) scl_o = 1'b1;
    #(HALF) sda_low_o = 1'b0;
    #(HALF*2);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(last, s);
  endtask
endmodule
`default_nettype wire

// ===== bench/twx_target_chk.sv
// checker: bus and port assertions bound into the two-wire target
`timescale 1ns/1ns
`default_nettype none
module twx_chk
  import twx_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [7:0] quasi_io_pins_o,
  input wire logic [7:0] quasi_io_pins_oe_o,
  input wire logic       alert_n_o,
  input wire logic       alert_n_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // cycles since the target last pulled data low, saturating
  logic [9:0] ack_age_q;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      ack_age_q <= 10'h3ff;
    else if (sda_oe_o)
      ack_age_q <= 10'h000;
    else if (ack_age_q != 10'h3ff)
      ack_age_q <= ack_age_q + 10'h001;
  ////////////////////////////////////////
  chk_sda_pull_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data driven high");
  chk_sda_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data moved while clock high");
  chk_ack_held: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("low level not held");
  chk_high_quiet: assert property ($rose(scl_i) |=> $stable(sda_oe_o) [*8])
    else $error("data moved in clock high");
  chk_start_listen: assert property ($fell(sda_i) && scl_i |=> !sda_oe_o [*8])
    else $error("driving after start");
  chk_stop_idle: assert property ($rose(sda_i) && scl_i |=> !sda_oe_o [*8])
    else $error("driving after stop");
  chk_port_after_ack: assert property ($changed(quasi_io_pins_oe_o) |->
    ack_age_q < PORT_DLY_CYC) else $error("port moved without write");
  chk_alert_release: assert property ($fell(alert_n_oe_o) |->
    ack_age_q < PORT_DLY_CYC) else $error("alert released without access");
  chk_port_pull_only: assert property (quasi_io_pins_o == 8'h00)
    else $error("port driven high");
  chk_alert_pull_low: assert property (alert_n_o == 1'b0)
    else $error("alert driven high");
  cover property ($rose(sda_oe_o));
  cover property ($rose(alert_n_oe_o));
  cover property ($changed(quasi_io_pins_oe_o));
endmodule
bind twx_target twx_chk i_twx_chk (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .quasi_io_pins_o(quasi_io_pins_o),
  .quasi_io_pins_oe_o(quasi_io_pins_oe_o), .alert_n_o(alert_n_o),
  .alert_n_oe_o(alert_n_oe_o));
`default_nettype wire

// ===== bench/twx_target_tb.sv
// testbench: two-wire target against a behavioural bus controller
`timescale 1ns/1ns
`default_nettype none
module twx_target_tb;
  import twx_pkg::*;
  localparam logic [2:0] SEL = 3'h5;
  logic       mclk;
  logic       rst;
  logic       scl;
  logic       host_low;
  logic       sda;
  logic       sda_oe;
  logic       alert_oe;
  logic [7:0] ext_pins;
  logic [7:0] pins;
  logic [7:0] pins_oe;
  logic       stall;
  int         fail_count;
  int         total_checks;
  // released lines float high through the pull-ups
  assign sda = !(host_low || sda_oe);
  assign pins = ext_pins & ~pins_oe;
  twx_host i_twx_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
  twx_target #(.DEPTH(FIFO_DEPTH)) i_twx_target (.mclk_i(mclk), .rst_i(rst), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .addr_select_pins_i(SEL),
    .quasi_io_pins_i(pins), .quasi_io_pins_o(), .quasi_io_pins_oe_o(pins_oe),
    .alert_n_o(), .alert_n_oe_o(alert_oe), .wr_stall_o(stall));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_alert(input logic exp);
    for (int n = 0; n < PORT_DLY_CYC && alert_oe !== exp; n++)
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic t_write(input logic g, input logic [7:0] d0, input logic [7:0] d1);
    logic a;
    i_twx_host.glitch = g;
    i_twx_host.start();
    i_twx_host.send({FIXED_ADDR, SEL, 1'b0}, a);
    i_twx_host.glitch = 1'b0;
    chk(a, 1'b1, "address ack");
    i_twx_host.send(d0, a);
    chk(a, 1'b1, "data ack");
    i_twx_host.send(d1, a);
    chk(a, 1'b1, "second ack");
    repeat (PORT_DLY_CYC / 2) @(posedge mclk);
    #1;
    chk(pins_oe, ~d1, "port");
    chk(stall, 1'b0, "stall");
    i_twx_host.stop();
  endtask
  task automatic rd(input logic [7:0] exp, input int n);
    logic       a;
    logic [7:0] b;
    i_twx_host.start();
    i_twx_host.send({FIXED_ADDR, SEL, 1'b1}, a);
    chk(a, 1'b1, "read ack");
    for (int k = 1; k <= n; k++)
    begin
      i_twx_host.recv(k == n, b);
      chk(b, exp, "read byte");
    end
    // give a wrongly resumed transmitter time to drive its first bit
    repeat (30) @(posedge mclk);
    #1;
    chk(sda_oe, 1'b0, "release");
    i_twx_host.stop();
  endtask
  task automatic t_read;
    t_write(1'b0, 8'h3c, 8'hff);
    rd(8'hff, 1);
    wait_alert(1'b0);
    chk(alert_oe, 1'b0, "alert kept");
    @(posedge mclk);
    #1 ext_pins = 8'h69;
    wait_alert(1'b1);
    chk(alert_oe, 1'b1, "no alert");
    rd(8'h69, 2);
    wait_alert(1'b0);
    chk(alert_oe, 1'b0, "alert kept");
  endtask
  task automatic t_refuse;
    logic a;
    i_twx_host.start();
    i_twx_host.send(8'h00, a);
    chk(a, 1'b0, "general call");
    i_twx_host.stop();
    i_twx_host.start();
    i_twx_host.send({FIXED_ADDR, ~SEL, 1'b0}, a);
    chk(a, 1'b0, "foreign address");
    i_twx_host.send(8'h00, a);
    chk(a, 1'b0, "foreign data");
    i_twx_host.stop();
    chk(pins_oe, 8'h00, "port");
  endtask
  ////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = !mclk;
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    final_report();
  end
  initial
  begin
    fail_count = 0;
    total_checks = 0;
    rst = 1'b1;
    ext_pins = 8'hff;
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk(pins_oe, 8'h00, "reset port");
    t_write(1'b1, 8'h5a, 8'h0f);
    t_read();
    t_refuse();
    final_report();
  end
endmodule
`default_nettype wire
